// ===== verilog/fcs_consts.svh
`ifndef FCS_CONSTS_SVH
`define FCS_CONSTS_SVH
// Parameter indices on the documented parameter port.
`define FCS_IDX_SLAVE_ADDRESS   16'h0000
`define FCS_IDX_LINE_SPEED      16'h0001
`define FCS_IDX_PARITY          16'h0002
`define FCS_IDX_LOSS_TIMEOUT    16'h0003
`define FCS_IDX_LOSS_ACTION     16'h0004
`define FCS_IDX_PROTOCOL        16'h0005
`define FCS_IDX_CMD_CHANNEL     16'h0006
`define FCS_IDX_LOC_A_CMD       16'h0007
`define FCS_IDX_LOC_B_CMD       16'h0008
`define FCS_IDX_ROTATION        16'h0009
`define FCS_IDX_LOC_CHOICE      16'h000A
`define FCS_IDX_LOC_A_REF       16'h000B
`define FCS_IDX_LOC_B_REF       16'h000C
`define FCS_IDX_RUN_PERMIT      16'h000D
`define FCS_IDX_FAULT_CLEAR     16'h000E
`define FCS_IDX_STATUS          16'h000F
// Reset values.
`define FCS_RST_SLAVE_ADDRESS   16'h0001
`define FCS_RST_LINE_SPEED      16'h0060
`define FCS_RST_PARITY          16'h0000
`define FCS_RST_LOSS_TIMEOUT    16'h000A
`define FCS_RST_LOSS_ACTION     16'h0000
`define FCS_RST_PROTOCOL        16'h0000
`define FCS_RST_CMD_CHANNEL     16'h0001
`define FCS_RST_LOC_A_CMD       16'h000A
`define FCS_RST_LOC_B_CMD       16'h000A
`define FCS_RST_ROTATION        16'h0003
`define FCS_RST_LOC_CHOICE      16'h0008
`define FCS_RST_LOC_A_REF       16'h0008
`define FCS_RST_LOC_B_REF       16'h0008
`define FCS_RST_RUN_PERMIT      16'h0006
`define FCS_RST_FAULT_CLEAR     16'h0007
// Legal ranges and codes.
`define FCS_ADDR_MIN            16'h0001
`define FCS_ADDR_MAX            16'h00F7
`define FCS_SPEED_MIN           16'h0003
`define FCS_SPEED_MAX           16'h0060
`define FCS_TIMEOUT_MIN         16'h0001
`define FCS_TIMEOUT_MAX         16'h0258
`define FCS_SRC_FIELDBUS_CMD    16'h000A
`define FCS_SRC_FIELDBUS_SEL    16'h0008
`define FCS_SRC_FIELDBUS_RUN    16'h0006
`define FCS_SRC_FIELDBUS_FLT    16'h0007
`define FCS_REF_PLUS            16'h0009
`define FCS_REF_TIMES           16'h000A
`define FCS_CMD_MAX             16'h000A
`define FCS_FLT_MAX             16'h0007
// Control word bit positions.
`define FCS_CW_RUN_BIT          3
`define FCS_CW_FLT_BIT          7
`define FCS_CW_LOC_BIT          11
// Timeout unit is 0.1 s; 100 ms at 5 ns per cycle.
`define FCS_TICK_MS             100
`define FCS_CLK_PERIOD_NS       5
`define FCS_TICK_CYCLES         ((`FCS_TICK_MS * 1000000) / `FCS_CLK_PERIOD_NS)
`endif

// ===== verilog/fcs_pkg.sv
package fcs_pkg;
    typedef enum logic [1:0] {
        FCS_PROTO_NONE,
        FCS_PROTO_OPTICAL,
        FCS_PROTO_STANDARD,
        FCS_PROTO_BOTH
    } fcs_proto_t;
    typedef enum logic [1:0] {
        FCS_LOSS_NOTHING,
        FCS_LOSS_FAULT,
        FCS_LOSS_PRESET_SEVEN,
        FCS_LOSS_LAST_SPEED
    } fcs_loss_t;
    typedef enum logic [1:0] {
        FCS_LINK_IDLE,
        FCS_LINK_ALIVE,
        FCS_LINK_LOST
    } fcs_link_state_t;
endpackage

// ===== verilog/fcs_control_select.sv
`timescale 1ns/1ps
`include "fcs_consts.svh"
// Function
// - Answer only the station address 1 to 247; address 1 after reset.
// - Line speed and parity must match the master to exchange at all.
// - Line speed code is rate over 100, 3 to 96, default 96.
// - Parity code 0 none, 1 even, 2 odd; default none.
// - Declare link loss after 0.1 to 60.0 s silence; default 1.0 s.
// - Loss reaction 0 nothing, 1 fault, 2 preset seven, 3 last speed.
// - Protocol 0 none, 1 optical, 2 standard, 3 both; default 0.
// - Accept fieldbus commands only in remote and with fieldbus as source.
// - Commands come from serial channel only with command channel choice 1.
// - Location A source 10 gives control word except bit 11 to A.
// - Location B source 10 gives control word except bit 11 to B.
// - Rotation 1 forward, 2 reverse, 3 from selected command source.
// - Location choice source 8 lets control word bit 11 pick location.
// - Location A reference 8 fieldbus ref 1, 9 plus analog, 10 times analog.
// - Location B reference 8 fieldbus ref 2, 9 plus analog, 10 times analog.
// - Run permit source 6 follows control word bit 3; 0 permits always.
// - Fault clear source 7 uses control word bit 7; 0 keypad only.
// - Activation with defaults runs 9600 bps, 8 data, no parity, two stops, station 1.
// - Line settings change only when the protocol selection is written again.
// - Out of reset the channel is inactive until a protocol is selected.
module fcs_control_select (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        par_wr,
    input  wire logic [15:0] par_idx,
    input  wire logic [15:0] par_wdata,
    output logic      [15:0] par_rdata,
    output logic             par_err,
    input  wire logic        frame_valid,
    input  wire logic [7:0]  frame_addr,
    input  wire logic [15:0] control_word,
    input  wire logic [15:0] fieldbus_ref1,
    input  wire logic [15:0] fieldbus_ref2,
    input  wire logic [15:0] analog_input_one,
    input  wire logic        remote_mode,
    input  wire logic        keypad_fault_clear,
    output logic             link_active,
    output logic [15:0]      active_line_speed,
    output logic [1:0]       active_parity,
    output logic [7:0]       active_address,
    output logic             frame_accept,
    output logic             link_lost,
    output logic             loss_fault,
    output logic             loss_preset_seven,
    output logic             loss_hold_speed,
    output logic             loc_b_selected,
    output logic [15:0]      loc_commands,
    output logic             loc_commands_valid,
    output logic             dir_reverse,
    output logic [31:0]      speed_reference,
    output logic             ref_valid,
    output logic             run_permit,
    output logic             fault_clear
);
    // Settings registers.
    logic [15:0] slave_address_q;
    logic [15:0] line_speed_code_q;
    logic [15:0] parity_select_q;
    logic [15:0] link_loss_timeout_q;
    logic [15:0] link_loss_action_q;
    logic [15:0] protocol_choice_q;
    logic [15:0] command_channel_choice_q;
    logic [15:0] loc_a_command_source_q;
    logic [15:0] loc_b_command_source_q;
    logic [15:0] rotation_sense_select_q;
    logic [15:0] location_choice_source_q;
    logic [15:0] loc_a_reference_source_q;
    logic [15:0] loc_b_reference_source_q;
    logic [15:0] run_permit_source_q;
    logic [15:0] fault_clear_source_q;
    logic        ok_d;
    logic        stat_write;
    logic [31:0] tick_cnt_q;
    logic [15:0] tenth_cnt_q;
    fcs_pkg::fcs_link_state_t link_state_q;

    // Range check for the addressed parameter; refused writes change nothing.
    always_comb begin
        ok_d = 1'b1;
        case (par_idx)
            `FCS_IDX_SLAVE_ADDRESS: ok_d = (par_wdata >= `FCS_ADDR_MIN) &&
                                           (par_wdata <= `FCS_ADDR_MAX);
            `FCS_IDX_LINE_SPEED:    ok_d = (par_wdata >= `FCS_SPEED_MIN) &&
                                           (par_wdata <= `FCS_SPEED_MAX);
            `FCS_IDX_PARITY:        ok_d = (par_wdata <= 16'h0002);
            `FCS_IDX_LOSS_TIMEOUT:  ok_d = (par_wdata >= `FCS_TIMEOUT_MIN) &&
                                           (par_wdata <= `FCS_TIMEOUT_MAX);
            `FCS_IDX_LOSS_ACTION:   ok_d = (par_wdata <= 16'h0003);
            `FCS_IDX_PROTOCOL:      ok_d = (par_wdata <= 16'h0003);
            `FCS_IDX_CMD_CHANNEL:   ok_d = (par_wdata <= 16'h0002);
            `FCS_IDX_LOC_A_CMD,
            `FCS_IDX_LOC_B_CMD:     ok_d = (par_wdata <= `FCS_CMD_MAX);
            `FCS_IDX_ROTATION:      ok_d = (par_wdata >= 16'h0001) &&
                                           (par_wdata <= 16'h0003);
            `FCS_IDX_LOC_CHOICE:    ok_d = (par_wdata >= 16'h0001) &&
                                           (par_wdata <= `FCS_SRC_FIELDBUS_SEL);
            `FCS_IDX_LOC_A_REF,
            `FCS_IDX_LOC_B_REF:     ok_d = (par_wdata <= `FCS_REF_TIMES);
            `FCS_IDX_RUN_PERMIT:    ok_d = (par_wdata <= `FCS_SRC_FIELDBUS_RUN);
            `FCS_IDX_FAULT_CLEAR:   ok_d = (par_wdata <= `FCS_FLT_MAX);
            default:                ok_d = 1'b0;
        endcase
    end

    assign stat_write = par_wr && ok_d;

    // Parameter store; each write lands only if in range.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slave_address_q          <= `FCS_RST_SLAVE_ADDRESS;
            line_speed_code_q        <= `FCS_RST_LINE_SPEED;
            parity_select_q          <= `FCS_RST_PARITY;
            link_loss_timeout_q      <= `FCS_RST_LOSS_TIMEOUT;
            link_loss_action_q       <= `FCS_RST_LOSS_ACTION;
            protocol_choice_q        <= `FCS_RST_PROTOCOL;
            command_channel_choice_q <= `FCS_RST_CMD_CHANNEL;
            loc_a_command_source_q   <= `FCS_RST_LOC_A_CMD;
            loc_b_command_source_q   <= `FCS_RST_LOC_B_CMD;
            rotation_sense_select_q  <= `FCS_RST_ROTATION;
            location_choice_source_q <= `FCS_RST_LOC_CHOICE;
            loc_a_reference_source_q <= `FCS_RST_LOC_A_REF;
            loc_b_reference_source_q <= `FCS_RST_LOC_B_REF;
            run_permit_source_q      <= `FCS_RST_RUN_PERMIT;
            fault_clear_source_q     <= `FCS_RST_FAULT_CLEAR;
        end else if (stat_write) begin
            case (par_idx)
                `FCS_IDX_SLAVE_ADDRESS: slave_address_q          <= par_wdata;
                `FCS_IDX_LINE_SPEED:    line_speed_code_q        <= par_wdata;
                `FCS_IDX_PARITY:        parity_select_q          <= par_wdata;
                `FCS_IDX_LOSS_TIMEOUT:  link_loss_timeout_q      <= par_wdata;
                `FCS_IDX_LOSS_ACTION:   link_loss_action_q       <= par_wdata;
                `FCS_IDX_PROTOCOL:      protocol_choice_q        <= par_wdata;
                `FCS_IDX_CMD_CHANNEL:   command_channel_choice_q <= par_wdata;
                `FCS_IDX_LOC_A_CMD:     loc_a_command_source_q   <= par_wdata;
                `FCS_IDX_LOC_B_CMD:     loc_b_command_source_q   <= par_wdata;
                `FCS_IDX_ROTATION:      rotation_sense_select_q  <= par_wdata;
                `FCS_IDX_LOC_CHOICE:    location_choice_source_q <= par_wdata;
                `FCS_IDX_LOC_A_REF:     loc_a_reference_source_q <= par_wdata;
                `FCS_IDX_LOC_B_REF:     loc_b_reference_source_q <= par_wdata;
                `FCS_IDX_RUN_PERMIT:    run_permit_source_q      <= par_wdata;
                `FCS_IDX_FAULT_CLEAR:   fault_clear_source_q     <= par_wdata;
                default: ;
            endcase
        end
    end

    // Readback and write refusal flag, answered one cycle after the request.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            par_rdata <= 16'h0000;
            par_err   <= 1'b0;
        end else begin
            par_err <= par_wr && !ok_d;
            case (par_idx)
                `FCS_IDX_SLAVE_ADDRESS: par_rdata <= slave_address_q;
                `FCS_IDX_LINE_SPEED:    par_rdata <= line_speed_code_q;
                `FCS_IDX_PARITY:        par_rdata <= parity_select_q;
                `FCS_IDX_LOSS_TIMEOUT:  par_rdata <= link_loss_timeout_q;
                `FCS_IDX_LOSS_ACTION:   par_rdata <= link_loss_action_q;
                `FCS_IDX_PROTOCOL:      par_rdata <= protocol_choice_q;
                `FCS_IDX_CMD_CHANNEL:   par_rdata <= command_channel_choice_q;
                `FCS_IDX_LOC_A_CMD:     par_rdata <= loc_a_command_source_q;
                `FCS_IDX_LOC_B_CMD:     par_rdata <= loc_b_command_source_q;
                `FCS_IDX_ROTATION:      par_rdata <= rotation_sense_select_q;
                `FCS_IDX_LOC_CHOICE:    par_rdata <= location_choice_source_q;
                `FCS_IDX_LOC_A_REF:     par_rdata <= loc_a_reference_source_q;
                `FCS_IDX_LOC_B_REF:     par_rdata <= loc_b_reference_source_q;
                `FCS_IDX_RUN_PERMIT:    par_rdata <= run_permit_source_q;
                `FCS_IDX_FAULT_CLEAR:   par_rdata <= fault_clear_source_q;
                `FCS_IDX_STATUS:        par_rdata <= {13'h0000, link_lost, link_active,
                                                      loc_b_selected};
                default:                par_rdata <= 16'h0000;
            endcase
        end
    end

    // Line settings are copied to the active set only when the protocol is
    // written again, so a half-finished reconfiguration never disturbs the line.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            link_active       <= 1'b0;
            active_line_speed <= `FCS_RST_LINE_SPEED;
            active_parity     <= 2'h0;
            active_address    <= 8'h01;
        end else if (stat_write && par_idx == `FCS_IDX_PROTOCOL) begin
            link_active       <= (par_wdata != 16'h0000);
            active_line_speed <= line_speed_code_q;
            active_parity     <= parity_select_q[1:0];
            active_address    <= slave_address_q[7:0];
        end
    end

    // Frame acceptance: only frames to our own station while the link is up.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_accept <= 1'b0;
        end else begin
            frame_accept <= link_active && frame_valid && (frame_addr == active_address);
        end
    end

    // Silence timer in tenths of a second; restarts on each accepted frame.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q   <= 32'h0000_0000;
            tenth_cnt_q  <= 16'h0000;
            link_state_q <= fcs_pkg::FCS_LINK_IDLE;
        end else if (!link_active) begin
            tick_cnt_q   <= 32'h0000_0000;
            tenth_cnt_q  <= 16'h0000;
            link_state_q <= fcs_pkg::FCS_LINK_IDLE;
        end else if (frame_accept) begin
            tick_cnt_q   <= 32'h0000_0000;
            tenth_cnt_q  <= 16'h0000;
            link_state_q <= fcs_pkg::FCS_LINK_ALIVE;
        end else begin
            case (link_state_q)
                fcs_pkg::FCS_LINK_IDLE,
                fcs_pkg::FCS_LINK_ALIVE: begin
                    if (tick_cnt_q == 32'(`FCS_TICK_CYCLES - 1)) begin
                        tick_cnt_q  <= 32'h0000_0000;
                        tenth_cnt_q <= tenth_cnt_q + 16'h0001;
                        if (tenth_cnt_q + 16'h0001 >= link_loss_timeout_q) begin
                            link_state_q <= fcs_pkg::FCS_LINK_LOST;
                        end
                    end else begin
                        tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
                    end
                end
                fcs_pkg::FCS_LINK_LOST: ;
                default: link_state_q <= fcs_pkg::FCS_LINK_IDLE;
            endcase
        end
    end

    // Loss reaction outputs follow the chosen action while the link is lost.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            link_lost         <= 1'b0;
            loss_fault        <= 1'b0;
            loss_preset_seven <= 1'b0;
            loss_hold_speed   <= 1'b0;
        end else begin
            link_lost         <= (link_state_q == fcs_pkg::FCS_LINK_LOST);
            loss_fault        <= (link_state_q == fcs_pkg::FCS_LINK_LOST) &&
                (link_loss_action_q[1:0] == fcs_pkg::FCS_LOSS_FAULT);
            loss_preset_seven <= (link_state_q == fcs_pkg::FCS_LINK_LOST) &&
                (link_loss_action_q[1:0] == fcs_pkg::FCS_LOSS_PRESET_SEVEN);
            loss_hold_speed   <= (link_state_q == fcs_pkg::FCS_LINK_LOST) &&
                (link_loss_action_q[1:0] == fcs_pkg::FCS_LOSS_LAST_SPEED);
        end
    end

    // Fieldbus gate: remote mode, standard protocol on, and serial channel chosen.
    logic fb_ok;
    logic sel_b;
    logic cmd_from_fb;
    logic [15:0] ref_src;
    logic [15:0] fb_ref;
    assign fb_ok = remote_mode && link_active && protocol_choice_q[1] &&
                   (command_channel_choice_q == 16'h0001);
    assign sel_b = (location_choice_source_q == `FCS_SRC_FIELDBUS_SEL) ?
                   control_word[`FCS_CW_LOC_BIT] : loc_b_selected;
    assign cmd_from_fb = sel_b ? (loc_b_command_source_q == `FCS_SRC_FIELDBUS_CMD)
                               : (loc_a_command_source_q == `FCS_SRC_FIELDBUS_CMD);
    assign ref_src = sel_b ? loc_b_reference_source_q : loc_a_reference_source_q;
    assign fb_ref  = sel_b ? fieldbus_ref2 : fieldbus_ref1;

    // Location choice holds when only fieldbus may change it and fieldbus is off.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            loc_b_selected <= 1'b0;
        end else if (fb_ok && location_choice_source_q == `FCS_SRC_FIELDBUS_SEL) begin
            loc_b_selected <= control_word[`FCS_CW_LOC_BIT];
        end
    end

    // Command routing and direction.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            loc_commands       <= 16'h0000;
            loc_commands_valid <= 1'b0;
            dir_reverse        <= 1'b0;
        end else begin
            loc_commands_valid <= fb_ok && cmd_from_fb;
            if (fb_ok && cmd_from_fb) begin
                loc_commands <= control_word & ~(16'h0001 << `FCS_CW_LOC_BIT);
            end
            case (rotation_sense_select_q)
                16'h0001: dir_reverse <= 1'b0;
                16'h0002: dir_reverse <= 1'b1;
                default: begin
                    if (fb_ok && cmd_from_fb) begin
                        dir_reverse <= control_word[0] == 1'b0 ? dir_reverse
                                                               : control_word[1];
                    end
                end
            endcase
        end
    end

    // Reference forming; product keeps full width to avoid overflow.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            speed_reference <= 32'h0000_0000;
            ref_valid       <= 1'b0;
        end else begin
            ref_valid <= fb_ok && (ref_src >= `FCS_SRC_FIELDBUS_SEL);
            if (fb_ok) begin
                case (ref_src)
                    `FCS_SRC_FIELDBUS_SEL: speed_reference <= {16'h0000, fb_ref};
                    `FCS_REF_PLUS:  speed_reference <= 32'(fb_ref) + 32'(analog_input_one);
                    `FCS_REF_TIMES: speed_reference <= fb_ref * analog_input_one;
                    default: ;
                endcase
            end
        end
    end

    // Run permit and fault clear.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_permit  <= 1'b0;
            fault_clear <= 1'b0;
        end else begin
            if (run_permit_source_q == 16'h0000) begin
                run_permit <= 1'b1;
            end else if (run_permit_source_q == `FCS_SRC_FIELDBUS_RUN) begin
                run_permit <= fb_ok && control_word[`FCS_CW_RUN_BIT];
            end else begin
                run_permit <= 1'b0;
            end
            fault_clear <= keypad_fault_clear ||
                ((fault_clear_source_q == `FCS_SRC_FIELDBUS_FLT) && fb_ok &&
                 control_word[`FCS_CW_FLT_BIT]);
        end
    end
endmodule // fcs_control_select

// ===== verification/fcs_control_select_properties.sv
`timescale 1ns/1ps
`include "fcs_consts.svh"
// Port-level checks of the selector; reset suspends all of them.
module fcs_control_select_properties (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        par_wr,
    input wire logic [15:0] par_idx,
    input wire logic [15:0] par_wdata,
    input wire logic        par_err,
    input wire logic        frame_valid,
    input wire logic [7:0]  frame_addr,
    input wire logic        link_active,
    input wire logic [15:0] active_line_speed,
    input wire logic [1:0]  active_parity,
    input wire logic [7:0]  active_address,
    input wire logic        frame_accept,
    input wire logic        loc_b_selected,
    input wire logic [15:0] loc_commands,
    input wire logic        loc_commands_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic proto_wr;
    logic own;
    // A protocol write is the only event allowed to move the line settings.
    assign proto_wr = par_wr && par_idx == `FCS_IDX_PROTOCOL;
    assign own = frame_valid && frame_addr == active_address;
    AST_OWN_FRAME: assert property (own && link_active |=> frame_accept)
        else $error("own frame not accepted");
    AST_FOREIGN_FRAME: assert property (frame_valid && !own |=> !frame_accept)
        else $error("foreign frame accepted");
    AST_IDLE_FRAME: assert property (frame_valid && !link_active |=> !frame_accept)
        else $error("frame accepted while idle");
    AST_STAY_IDLE: assert property (!link_active && !proto_wr |=> !link_active)
        else $error("link woke without protocol write");
    AST_SPEED_HELD: assert property (!proto_wr |=> $stable(active_line_speed))
        else $error("line speed moved without protocol write");
    AST_SPEED_RANGE: assert property (active_line_speed inside {[3:96]})
        else $error("line speed out of range");
    AST_PARITY_CODE: assert property (active_parity != 2'h3)
        else $error("illegal parity code");
    AST_ADDR_REFUSED: assert property (par_wr && par_idx == 16'h0000
        && !(par_wdata inside {[1:247]}) |=> par_err ##1 active_address inside {[1:247]})
        else $error("bad address not refused");
    AST_BIT11_CLEAR: assert property (loc_commands_valid |-> !loc_commands[11])
        else $error("location bit leaked");
    COV_ACCEPT: cover property (frame_accept);
    COV_LOC_B: cover property (loc_b_selected && loc_commands_valid);
    COV_REFUSE: cover property (par_err);
endmodule // fcs_control_select_properties
bind fcs_control_select fcs_control_select_properties chk_u (.*);

// ===== verification/fcs_fieldbus_master.sv
`timescale 1ns/1ps
// Far-side master: one-cycle frames after an optional idle gap.
module fcs_fieldbus_master (
    input wire logic    clk,
    output logic        frame_valid,
    output logic [7:0]  frame_addr,
    output logic [15:0] control_word,
    output logic [15:0] fieldbus_ref1,
    output logic [15:0] fieldbus_ref2
);
    initial begin
        frame_valid = 1'b0;
        frame_addr = 8'hA5;
        control_word = 16'h0000;
        fieldbus_ref1 = 16'h0000;
        fieldbus_ref2 = 16'h0000;
    end
    // The station field flips after a frame so a stale value never matches.
    task automatic send(input logic [7:0] a, input logic [15:0] cw, r1, r2, input int gap);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        frame_valid <= 1'b1;
        frame_addr <= a;
        control_word <= cw;
        fieldbus_ref1 <= r1;
        fieldbus_ref2 <= r2;
        @(posedge clk);
        frame_valid <= 1'b0;
        frame_addr <= ~a;
    endtask
endmodule // fcs_fieldbus_master

// ===== verification/fcs_control_select_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
    $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module fcs_control_select_tb;
    logic clk = 0, rst_n = 0, par_wr = 0, remote_mode = 0, keypad_fault_clear = 0;
    logic [15:0] par_idx = 0, par_wdata = 0, analog_input_one = 16'h0004;
    logic [15:0] par_rdata, active_line_speed, loc_commands, cw, r1, r2;
    logic [7:0] active_address, fa;
    logic [1:0] active_parity;
    logic [31:0] speed_reference;
    logic par_err, link_active, frame_accept, loc_b_selected, loc_commands_valid, fv;
    logic dir_reverse, run_permit, fault_clear, last_err, ref_valid;
    int errors = 0, cmp_count = 0, cyc = 0;
    logic [15:0] rst_tab [7] = '{16'h0001, 16'h0060, 16'h0000, 16'h000A, 16'h0000,
        16'h0000, 16'h0001};
    fcs_fieldbus_master mst_u (.clk(clk), .frame_valid(fv), .frame_addr(fa),
        .control_word(cw), .fieldbus_ref1(r1), .fieldbus_ref2(r2));
    fcs_control_select dut_u (.clk(clk), .rst_n(rst_n), .par_wr(par_wr), .par_idx(par_idx),
        .par_wdata(par_wdata), .par_rdata(par_rdata), .par_err(par_err), .frame_valid(fv),
        .frame_addr(fa), .control_word(cw), .fieldbus_ref1(r1), .fieldbus_ref2(r2),
        .analog_input_one(analog_input_one), .remote_mode(remote_mode),
        .keypad_fault_clear(keypad_fault_clear), .link_active(link_active),
        .active_line_speed(active_line_speed), .active_parity(active_parity),
        .active_address(active_address), .frame_accept(frame_accept), .link_lost(),
        .loss_fault(), .loss_preset_seven(), .loss_hold_speed(),
        .loc_b_selected(loc_b_selected), .loc_commands(loc_commands),
        .loc_commands_valid(loc_commands_valid), .dir_reverse(dir_reverse),
        .speed_reference(speed_reference), .ref_valid(ref_valid), .run_permit(run_permit),
        .fault_clear(fault_clear));
    // Free-running clock; a hang is cut short at a cycle ceiling.
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // One write strobe; the refusal flag is caught once it has landed.
    task automatic wr(input logic [15:0] i, d);
        @(posedge clk);
        par_wr <= 1'b1;
        par_idx <= i;
        par_wdata <= d;
        @(posedge clk);
        par_wr <= 1'b0;
        #1 last_err = par_err;
    endtask
    task automatic rd(input logic [15:0] i, output logic [15:0] d);
        @(posedge clk);
        par_idx <= i;
        @(posedge clk);
        #1 d = par_rdata;
    endtask
    task automatic frame(input logic [7:0] a, input logic e);
        mst_u.send(a, cw, r1, r2, 2);
        #1 `CHK(frame_accept, e)
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic t_defaults();
        logic [15:0] v;
        for (int i = 0; i < 7; i++) begin
            rd(i[15:0], v);
            `CHK(v, rst_tab[i])
        end
        frame(8'h01, 1'b0);
        $display("defaults done");
    endtask
    task automatic t_activate();
        wr(16'h0005, 16'h0002);
        `CHK({link_active, active_line_speed, active_parity, active_address},
            {1'b1, 16'h0060, 2'h0, 8'h01})
        frame(8'h01, 1'b1);
        wr(16'h0001, 16'h0003);
        wr(16'h0002, 16'h0001);
        wr(16'h0000, 16'h0005);
        `CHK({active_line_speed, active_parity, active_address}, {16'h0060, 2'h0, 8'h01})
        frame(8'h05, 1'b0);
        wr(16'h0005, 16'h0002);
        `CHK({active_line_speed, active_parity, active_address}, {16'h0003, 2'h1, 8'h05})
        frame(8'h05, 1'b1);
        frame(8'h01, 1'b0);
        $display("activate done");
    endtask
    task automatic t_refuse();
        logic [15:0] v;
        wr(16'h0000, 16'h0000);
        `CHK(last_err, 1'b1)
        wr(16'h0000, 16'h00F8);
        `CHK(last_err, 1'b1)
        wr(16'h0002, 16'h0003);
        `CHK(last_err, 1'b1)
        rd(16'h0000, v);
        `CHK(v, 16'h0005)
        wr(16'h0000, 16'h00F7);
        `CHK(last_err, 1'b0)
        $display("refuse done");
    endtask
    task automatic t_route();
        @(posedge clk) remote_mode <= 1'b1;
        mst_u.send(8'h05, 16'h088B, 16'h0123, 16'h0003, 0);
        settle();
        `CHK({loc_b_selected, loc_commands, loc_commands_valid}, {1'b1, 16'h008B, 1'b1})
        `CHK({run_permit, fault_clear, ref_valid, dir_reverse, speed_reference},
            {4'hF, 32'h3})
        wr(16'h000C, 16'h0009);
        settle();
        `CHK(speed_reference, 32'h7)
        wr(16'h000C, 16'h000A);
        settle();
        `CHK(speed_reference, 32'hC)
        mst_u.send(8'h05, 16'h0000, 16'h0123, 16'h0003, 0);
        settle();
        `CHK({loc_b_selected, loc_commands, run_permit}, {1'b0, 16'h0000, 1'b0})
        `CHK(speed_reference, 32'h123)
        wr(16'h0009, 16'h0001);
        settle();
        `CHK(dir_reverse, 1'b0)
        wr(16'h0009, 16'h0002);
        settle();
        `CHK(dir_reverse, 1'b1)
        @(posedge clk) remote_mode <= 1'b0;
        settle();
        `CHK(loc_commands_valid, 1'b0)
        @(posedge clk) remote_mode <= 1'b1;
        wr(16'h0006, 16'h0000);
        settle();
        `CHK(loc_commands_valid, 1'b0)
        $display("route done");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_defaults();
        t_activate();
        t_refuse();
        t_route();
        give_verdict();
    end
endmodule // fcs_control_select_tb
